/* File: common/amp_diag_pkg.sv */
// Constants of the amplifier control and diagnostic register bank.
// Assumes a byte-wide two-wire target bus and 8-bit registers.
package amp_diag_pkg;
  localparam logic [6:0] DEV_ADDR7     = 7'h6C;
  localparam logic [7:0] OFS_FAULT     = 8'h01;
  localparam logic [7:0] OFS_STATUS    = 8'h02;
  localparam logic [7:0] OFS_CTRL      = 8'h03;
  localparam logic [7:0] FAULT_RST     = 8'h00;
  localparam logic [7:0] CTRL_RST      = 8'h78;
  localparam logic [7:0] FAULT_USED    = 8'hFC;
  localparam int         GAIN_MSB      = 7;
  localparam int         GAIN_LSB      = 6;
  localparam int         LIM_MSB       = 5;
  localparam int         LIM_LSB       = 3;
  localparam int         FREQ_BIT      = 0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_SUB, ST_SUB_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_MACK
  } bus_state_e;
endpackage

/* File: core/amp_diag_regs.sv */
// Two-wire target with latched fault, live status and control registers.
// Assumes bus pins are already synchronous to i_core_clk and slow against it.
// Function
// - Answer only device address, master starts all.
// - Decode fault, status and control at 1..3.
// - Fault register zero by default, bits 1:0 reserved.
// - Fault bit 2 latches load diagnostic fault.
// - Fault bit 3 latches overcurrent shutdown.
// - Fault bit 4 latches supply undervoltage.
// - Fault bit 5 latches supply overvoltage.
// - Fault bit 6 latches output offset trip.
// - Fault bit 7 latches overheat shutdown.
// - Status register zero when nothing reported.
// - Status bits 0/1 show supply/ground shorts.
// - Status bit 2 shows open load.
// - Status bit 3 shows shorted load.
// - Status bits 7:4 show play/mute/diagnostic/fault.
// - Control resets 0x78, bits 7:6 select gain.
// - Control bit 0 selects switching frequency.
// - Control bits 5:3 select peak limiter.
// - Low limiter codes give tighter limits.
// - Without master, defaults apply, fault pin reports.
// - Fault pin pulled low while stage forced idle.
// - Register pointer advances after each data byte written or read byte acknowledged.
`timescale 1ns/100ps
module amp_diag_regs (
  // Clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_n,
  // Bus pins
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda,
  output logic            o_sda_oe,
  // Fault events
  input  wire logic       i_ev_load_diag,
  input  wire logic       i_ev_overcurrent,
  input  wire logic       i_ev_undervoltage,
  input  wire logic       i_ev_overvoltage,
  input  wire logic       i_ev_dc_offset,
  input  wire logic       i_ev_overheat_shutdown,
  // Live status
  input  wire logic       i_short_to_supply,
  input  wire logic       i_short_to_ground,
  input  wire logic       i_open_load,
  input  wire logic       i_shorted_load,
  input  wire logic       i_in_fault,
  input  wire logic       i_in_diag,
  input  wire logic       i_in_mute,
  input  wire logic       i_in_play,
  // Fault pin
  input  wire logic       i_stage_hiz_fault,
  output logic            o_fault_n,
  output logic            o_fault_oe,
  // Control outputs
  output logic [1:0]      o_gain_sel,
  output logic            o_sw_freq_sel,
  output logic [2:0]      o_limiter_sel
);
  amp_diag_pkg::bus_state_e st_q, st_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d, ctrl_q, ctrl_d, fault_q, fault_d;
  logic       rw_q, rw_d, oe_q, oe_d, scl_q, sda_q, pin_q;
  logic       rise, fall, start, stop, rd_fault;
  logic [7:0] ev, status;

  assign rise  = i_scl && !scl_q;
  assign fall  = !i_scl && scl_q;
  assign start = i_scl && scl_q && sda_q && !i_sda;
  assign stop  = i_scl && scl_q && !sda_q && i_sda;
  assign ev = {i_ev_overheat_shutdown, i_ev_dc_offset, i_ev_overvoltage, i_ev_undervoltage,
               i_ev_overcurrent, i_ev_load_diag, 2'b00};
  assign status = {i_in_play, i_in_mute, i_in_diag, i_in_fault,
                   i_shorted_load, i_open_load, i_short_to_ground, i_short_to_supply};

  // Unmapped pointers read as zero so a long burst cannot alias the bank.
  function automatic logic [7:0] reg_read(input logic [7:0] p, input logic [7:0] f,
                                          input logic [7:0] s, input logic [7:0] c);
    logic [7:0] r;
    r = 8'h00;
    if (p == amp_diag_pkg::OFS_FAULT) r = f;
    else if (p == amp_diag_pkg::OFS_STATUS) r = s;
    else if (p == amp_diag_pkg::OFS_CTRL) r = c;
    return r;
  endfunction

  always_comb begin
    st_d     = st_q;
    bit_d    = bit_q;
    sh_d     = sh_q;
    ptr_d    = ptr_q;
    rw_d     = rw_q;
    oe_d     = oe_q;
    ctrl_d   = ctrl_q;
    rd_fault = 1'b0;
    if (start) begin
      st_d  = amp_diag_pkg::ST_ADDR;
      bit_d = 4'h0;
      oe_d  = 1'b0;
    end else if (stop) begin
      st_d = amp_diag_pkg::ST_IDLE;
      oe_d = 1'b0;
    end else begin
      unique case (st_q)
        amp_diag_pkg::ST_IDLE: begin
          oe_d = 1'b0;
        end
        amp_diag_pkg::ST_ADDR, amp_diag_pkg::ST_SUB, amp_diag_pkg::ST_WR: begin
          if (rise) begin
            sh_d  = {sh_q[6:0], i_sda};
            bit_d = bit_q + 4'h1;
          end else if (fall && bit_q == amp_diag_pkg::BITS_PER_BYTE) begin
            oe_d = 1'b1;
            if (st_q == amp_diag_pkg::ST_ADDR) begin
              if (sh_q[7:1] == amp_diag_pkg::DEV_ADDR7) begin
                st_d = amp_diag_pkg::ST_ADDR_ACK;
                rw_d = sh_q[0];
              end else begin
                st_d = amp_diag_pkg::ST_IDLE;
                oe_d = 1'b0;
              end
            end else if (st_q == amp_diag_pkg::ST_SUB) begin
              st_d  = amp_diag_pkg::ST_SUB_ACK;
              ptr_d = sh_q;
            end else begin
              st_d = amp_diag_pkg::ST_WR_ACK;
              if (ptr_q == amp_diag_pkg::OFS_CTRL) ctrl_d = sh_q;
            end
          end
        end
        amp_diag_pkg::ST_ADDR_ACK, amp_diag_pkg::ST_SUB_ACK, amp_diag_pkg::ST_WR_ACK: begin
          if (fall) begin
            bit_d = 4'h0;
            oe_d  = 1'b0;
            if (st_q == amp_diag_pkg::ST_WR_ACK) ptr_d = ptr_q + 8'h01;
            if (st_q == amp_diag_pkg::ST_ADDR_ACK && rw_q) begin
              st_d     = amp_diag_pkg::ST_RD;
              sh_d     = reg_read(ptr_q, fault_q, status, ctrl_q);
              oe_d     = !sh_d[7];
              rd_fault = (ptr_q == amp_diag_pkg::OFS_FAULT);
            end else if (st_q == amp_diag_pkg::ST_ADDR_ACK) begin
              st_d = amp_diag_pkg::ST_SUB;
            end else begin
              st_d = amp_diag_pkg::ST_WR;
            end
          end
        end
        amp_diag_pkg::ST_RD: begin
          if (rise) begin
            bit_d = bit_q + 4'h1;
          end else if (fall) begin
            if (bit_q == amp_diag_pkg::BITS_PER_BYTE) begin
              st_d = amp_diag_pkg::ST_MACK;
              oe_d = 1'b0;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              oe_d = !sh_q[6];
            end
          end
        end
        amp_diag_pkg::ST_MACK: begin
          if (rise) begin
            if (i_sda) st_d = amp_diag_pkg::ST_IDLE;
            else ptr_d = ptr_q + 8'h01;
          end else if (fall) begin
            st_d     = amp_diag_pkg::ST_RD;
            bit_d    = 4'h0;
            sh_d     = reg_read(ptr_q, fault_q, status, ctrl_q);
            oe_d     = !sh_d[7];
            rd_fault = (ptr_q == amp_diag_pkg::OFS_FAULT);
          end
        end
      endcase
    end
    // A read clears the copy just sent; an event in the same cycle still sets.
    fault_d = ((rd_fault ? amp_diag_pkg::FAULT_RST : fault_q) | ev)
              & amp_diag_pkg::FAULT_USED;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q    <= amp_diag_pkg::ST_IDLE;
      bit_q   <= 4'h0;
      sh_q    <= 8'h00;
      ptr_q   <= 8'h00;
      rw_q    <= 1'b0;
      oe_q    <= 1'b0;
      ctrl_q  <= amp_diag_pkg::CTRL_RST;
      fault_q <= amp_diag_pkg::FAULT_RST;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      pin_q   <= 1'b0;
    end else begin
      st_q    <= st_d;
      bit_q   <= bit_d;
      sh_q    <= sh_d;
      ptr_q   <= ptr_d;
      rw_q    <= rw_d;
      oe_q    <= oe_d;
      ctrl_q  <= ctrl_d;
      fault_q <= fault_d;
      scl_q   <= i_scl;
      sda_q   <= i_sda;
      pin_q   <= i_stage_hiz_fault;
    end
  end

  assign o_sda         = 1'b0;
  assign o_sda_oe      = oe_q;
  assign o_fault_n     = 1'b0;
  assign o_fault_oe    = pin_q;
  assign o_gain_sel    = ctrl_q[amp_diag_pkg::GAIN_MSB:amp_diag_pkg::GAIN_LSB];
  assign o_sw_freq_sel = ctrl_q[amp_diag_pkg::FREQ_BIT];
  assign o_limiter_sel = ctrl_q[amp_diag_pkg::LIM_MSB:amp_diag_pkg::LIM_LSB];

  sequence mack_ok_s;
    st_q == amp_diag_pkg::ST_MACK && rise && !i_sda && !start && !stop;
  endsequence

  sequence ctrl_wr_s;
    st_q == amp_diag_pkg::ST_WR && fall && bit_q == amp_diag_pkg::BITS_PER_BYTE && !start && !stop
      && ptr_q == amp_diag_pkg::OFS_CTRL;
  endsequence

  // Byte ends and acknowledge slots fall while the bus clock is low, so no start or stop overlaps them.
  sequence foreign_addr_s;
    st_q == amp_diag_pkg::ST_ADDR && fall && bit_q == amp_diag_pkg::BITS_PER_BYTE
      && sh_q[7:1] != amp_diag_pkg::DEV_ADDR7;
  endsequence

  sequence nack_s;
    st_q == amp_diag_pkg::ST_MACK && rise && i_sda;
  endsequence

  sequence status_load_s;
    st_q == amp_diag_pkg::ST_ADDR_ACK && fall && rw_q && ptr_q == amp_diag_pkg::OFS_STATUS;
  endsequence

  sequence ro_write_s;
    st_q == amp_diag_pkg::ST_WR && fall && bit_q == amp_diag_pkg::BITS_PER_BYTE
      && ptr_q != amp_diag_pkg::OFS_CTRL;
  endsequence

  sequence rd_shift_s;
    st_q == amp_diag_pkg::ST_RD && fall && bit_q != amp_diag_pkg::BITS_PER_BYTE;
  endsequence

  sequence fault_load_s;
    rd_fault && ev == amp_diag_pkg::FAULT_RST;
  endsequence

  addr_match_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    st_q == amp_diag_pkg::ST_ADDR_ACK |-> sh_q[7:1] == amp_diag_pkg::DEV_ADDR7)
    else $error("Acknowledged a foreign address.");
  ptr_advance_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    mack_ok_s |=> ptr_q == $past(ptr_q) + 8'h01)
    else $error("Pointer did not advance after an acknowledged byte.");
  ctrl_write_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    ctrl_wr_s |=> ctrl_q == $past(sh_q) ##1 o_gain_sel == $past(sh_q, 2) >> amp_diag_pkg::GAIN_LSB)
    else $error("Control write not stored.");
  fault_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    fault_q[7] && !rd_fault |=> fault_q[7])
    else $error("Latched fault dropped without a read.");
  overheat_set_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_ev_overheat_shutdown |=> fault_q[7])
    else $error("Overheat event not latched.");
  overcur_set_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_ev_overcurrent |=> fault_q[3])
    else $error("Overcurrent event not latched.");
  reserved_zero_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    fault_q[1:0] == 2'b00)
    else $error("Reserved fault bits set.");
  fault_pin_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $rose(i_stage_hiz_fault) |=> o_fault_oe ##1 (o_fault_oe == $past(i_stage_hiz_fault)))
    else $error("Fault pin does not follow the stage.");
  foreign_nack_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    foreign_addr_s |=> st_q == amp_diag_pkg::ST_IDLE && !o_sda_oe)
    else $error("Foreign address not ignored.");
  stop_idle_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    stop |=> st_q == amp_diag_pkg::ST_IDLE && !o_sda_oe)
    else $error("Stop did not release the bus.");
  nack_end_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    nack_s |=> st_q == amp_diag_pkg::ST_IDLE && ptr_q == $past(ptr_q))
    else $error("Read not ended by a not-acknowledge.");
  status_load_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    status_load_s |=> sh_q == $past(status) && o_sda_oe == !$past(status[7]))
    else $error("Status byte not loaded from live inputs.");
  ro_write_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    ro_write_s |=> ctrl_q == $past(ctrl_q))
    else $error("Write to a read-only location changed control.");
  rd_shift_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    rd_shift_s |=> o_sda_oe == !$past(sh_q[6]))
    else $error("Read data bit not driven in order.");
  fault_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    fault_load_s |=> fault_q == amp_diag_pkg::FAULT_RST)
    else $error("Fault register not cleared by its read.");
  load_diag_set_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_ev_load_diag |=> fault_q[2])
    else $error("Load diagnostic event not latched.");
  undervolt_set_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_ev_undervoltage |=> fault_q[4])
    else $error("Undervoltage event not latched.");
  overvolt_set_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_ev_overvoltage |=> fault_q[5])
    else $error("Overvoltage event not latched.");
  offset_set_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_ev_dc_offset |=> fault_q[6])
    else $error("Offset event not latched.");
endmodule

/* File: bench/i2c_host_model.sv */
// Behavioural two-wire bus master that drives the register bank.
// Assumes a pull-up on the data wire, resolved by the testbench.
`timescale 1ns/100ps
module i2c_host_model (
  // Clock
  input  wire logic i_core_clk,
  // Bus
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  initial begin
    o_scl = 1'h1;
    o_sda_low = 1'h0;
  end
  // Four core cycles a phase keeps clear of the two-cycle minimum.
  task automatic half();
    repeat (4) @(negedge i_core_clk);
  endtask
  // Only this model ever opens a transfer; it also makes the repeated start.
  task automatic start_cond();
    half();
    o_sda_low = 1'h0;
    half();
    o_scl = 1'h1;
    half();
    o_sda_low = 1'h1;
    half();
    o_scl = 1'h0;
  endtask
  task automatic stop_cond();
    half();
    o_sda_low = 1'h1;
    half();
    o_scl = 1'h1;
    half();
    o_sda_low = 1'h0;
    half();
  endtask
  // Data moves only while the clock is low, so no false start or stop appears.
  task automatic xfer_bit(input logic b, output logic r);
    half();
    o_sda_low = ~b;
    half();
    o_scl = 1'h1;
    half();
    r = i_sda;
    o_scl = 1'h0;
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xfer_bit(d[i], r);
    xfer_bit(1'h1, r);
    ack = ~r;
  endtask
  // Every byte but the last is acknowledged.
  task automatic recv_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'h1, r);
      d[i] = r;
    end
    xfer_bit(~more, r);
  endtask
endmodule

/* File: bench/amp_diag_regs_test.sv */
// Self-checking testbench of the amplifier register bank.
// Assumes the bus master model drives the bus pins; the bench drives the rest.
`timescale 1ns/100ps
module amp_diag_regs_test;
  logic       clk = 1'h0;
  logic       rst_n = 1'h0;
  logic       scl, sda_low, sda_oe, sda_val, fault_n, fault_oe, freq, hiz = 1'h0, a;
  logic [5:0] ev = 6'h00;
  logic [7:0] st = 8'h00;
  logic [1:0] gain;
  logic [2:0] lim;
  logic [7:0] rdat [0:2];
  int         n_errors = 0;
  int         total_checks = 0;
  wire        sda = ~(sda_low | (sda_oe & ~sda_val));
  always #12.5 clk = ~clk;
  i2c_host_model host (.i_core_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
  amp_diag_regs amp_diag_regs_inst (.i_core_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda), .o_sda(sda_val),
    .o_sda_oe(sda_oe), .i_ev_load_diag(ev[0]), .i_ev_overcurrent(ev[1]), .i_ev_undervoltage(ev[2]),
    .i_ev_overvoltage(ev[3]), .i_ev_dc_offset(ev[4]), .i_ev_overheat_shutdown(ev[5]),
    .i_short_to_supply(st[0]), .i_short_to_ground(st[1]), .i_open_load(st[2]), .i_shorted_load(st[3]),
    .i_in_fault(st[4]), .i_in_diag(st[5]), .i_in_mute(st[6]), .i_in_play(st[7]),
    .i_stage_hiz_fault(hiz), .o_fault_n(fault_n), .o_fault_oe(fault_oe), .o_gain_sel(gain),
    .o_sw_freq_sel(freq), .o_limiter_sel(lim));
  task automatic end_sim();
    if (n_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] ptr, input logic [7:0] d);
    logic a1, a2, a3;
    host.start_cond();
    host.send_byte(8'hD8, a1);
    host.send_byte(ptr, a2);
    host.send_byte(d, a3);
    host.stop_cond();
    chk("write ack", 8'h01, {7'h00, a1 & a2 & a3});
  endtask
  task automatic rd_reg(input logic [7:0] ptr, input int n);
    host.start_cond();
    host.send_byte(8'hD8, a);
    host.send_byte(ptr, a);
    host.start_cond();
    host.send_byte(8'hD9, a);
    for (int i = 0; i < n; i++) host.recv_byte(i < n - 1, rdat[i]);
    host.stop_cond();
  endtask
  task automatic s_reset();
    chk("gain", 8'h01, {6'h00, gain});
    chk("limiter", 8'h07, {5'h00, lim});
    chk("freq", 8'h00, {7'h00, freq});
    rd_reg(8'h01, 3);
    chk("fault reg", 8'h00, rdat[0]);
    chk("status reg", 8'h00, rdat[1]);
    chk("ctrl reg", 8'h78, rdat[2]);
  endtask
  task automatic s_ctrl();
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      v = {i[1:0], i[2:0], 2'h2, i[0]};
      wr_reg(8'h03, v);
      chk("gain", {6'h00, v[7:6]}, {6'h00, gain});
      chk("limiter", {5'h00, v[5:3]}, {5'h00, lim});
      chk("freq", {7'h00, v[0]}, {7'h00, freq});
      rd_reg(8'h03, 1);
      chk("ctrl readback", v, rdat[0]);
    end
  endtask
  task automatic s_refuse();
    host.start_cond();
    host.send_byte(8'hDA, a);
    host.stop_cond();
    chk("foreign ack", 8'h00, {7'h00, a});
    wr_reg(8'h01, 8'hFF);
    wr_reg(8'h02, 8'hFF);
    rd_reg(8'h01, 2);
    chk("fault ro", 8'h00, rdat[0]);
    chk("status ro", 8'h00, rdat[1]);
  endtask
  task automatic s_fault();
    for (int k = 0; k < 6; k++) begin
      ev = 6'h01 << k;
      repeat (2) @(negedge clk);
      ev = 6'h00;
      repeat (4) @(negedge clk);
      rd_reg(8'h01, 1);
      chk("fault latch", 8'h04 << k, rdat[0]);
      rd_reg(8'h01, 1);
      chk("fault clear", 8'h00, rdat[0]);
    end
  endtask
  task automatic s_status();
    for (int k = 0; k < 8; k++) begin
      st = 8'h01 << k;
      rd_reg(8'h02, 1);
      chk("status bit", 8'h01 << k, rdat[0]);
      st = 8'h00;
    end
  endtask
  task automatic s_pin();
    hiz = 1'h1;
    repeat (2) @(negedge clk);
    chk("fault pin", 8'h02, {6'h00, fault_oe, fault_n});
    hiz = 1'h0;
    repeat (2) @(negedge clk);
    chk("fault pin idle", 8'h00, {6'h00, fault_oe, fault_n});
  endtask
  task automatic s_burst();
    host.start_cond();
    host.send_byte(8'hD8, a);
    host.send_byte(8'h02, a);
    host.send_byte(8'hFF, a);
    host.send_byte(8'h5A, a);
    host.stop_cond();
    chk("burst ack", 8'h01, {7'h00, a});
    chk("burst gain", 8'h01, {6'h00, gain});
    chk("burst limiter", 8'h03, {5'h00, lim});
    rd_reg(8'h03, 2);
    chk("burst write", 8'h5A, rdat[0]);
    chk("unmapped", 8'h00, rdat[1]);
  endtask
  task automatic s_midrst();
    hiz = 1'h1;
    repeat (3) @(negedge clk);
    rst_n = 1'h0;
    repeat (2) @(negedge clk);
    chk("reset pin", 8'h00, {7'h00, fault_oe});
    chk("reset gain", 8'h01, {6'h00, gain});
    chk("reset sda", 8'h00, {7'h00, sda_oe});
    hiz = 1'h0;
    rst_n = 1'h1;
    repeat (2) @(negedge clk);
    s_reset();
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'h1;
    repeat (2) @(negedge clk);
    s_reset();
    s_ctrl();
    s_refuse();
    s_fault();
    s_status();
    s_pin();
    s_burst();
    s_midrst();
    end_sim();
  end
  // A hang counts as a mismatch and still reaches the verdict.
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    end_sim();
  end
endmodule
